// ==== core/dfa_defs.vh ====
// constants for the drive flags and analog input register bank
`ifndef DFA_DEFS_VH
`define DFA_DEFS_VH

// object indices
`define DFA_IDX_DRIVE_FLAGS 16'h3212
`define DFA_IDX_ANALOG_IN 16'h3220
`define DFA_IDX_ANALOG_SEL 16'h3221
`define DFA_IDX_DIP_SW 16'h3225

// subindices
`define DFA_SUB_COUNT 8'h00
`define DFA_SUB_ONE 8'h01
`define DFA_SUB_TWO 8'h02
`define DFA_SUB_THREE 8'h03

// entry counts
`define DFA_DRIVE_FLAGS_COUNT 8'h03
`define DFA_ANALOG_COUNT 8'h02
`define DFA_DIP_COUNT 8'h01

// reset values
`define DFA_FLAG_RESET 8'h00
`define DFA_SEL_RESET 2'h0
`define DFA_READING_RESET 16'h0000
`define DFA_DIP_RESET 16'h0000

// flag encodings
`define DFA_FLAG_ON 8'h01
`define DFA_DIR_DEFAULT 8'h00
`define DFA_DIR_POSITIVE 8'h01
`define DFA_DIR_NEGATIVE 8'hff

// measurement select field
`define DFA_SEL_W 2
`define DFA_SEL_AIN1_BIT 0
`define DFA_SEL_AIN2_BIT 1

// scaling: full count of 1024 digits is 10 V or 20 mA
`define DFA_DIGITS_SHIFT 10
`define DFA_VOLT_FS_MV 16'h2710
`define DFA_CUR_FS_UA 16'h4e20

// auto setup states
`define DFA_AS_IDLE 2'h0
`define DFA_AS_DETECT 2'h1
`define DFA_AS_LOAD 2'h2
`define DFA_AS_RUN 2'h3

`endif

// ==== core/dfa_ain_chan.v ====
// one analog input channel: instantaneous reading and scaled value
`default_nettype none
`include "dfa_defs.vh"

module dfa_ain_chan
(
  input wire clk,
  input wire arst_n,
  input wire [15:0] raw_digits,
  input wire current_sel,
  output reg [15:0] reading_ff,
  output reg [31:0] scaled_ff
);

////////////////////////////////////////////////////////////////////////
// scaling of the current reading
wire signed [31:0] raw_ext;
wire signed [31:0] full_scale;
wire signed [31:0] product;
wire signed [31:0] nxt_scaled;

assign raw_ext = {{16{reading_ff[15]}}, reading_ff};
// voltage in mV or current in uA per full count
assign full_scale = current_sel ? {16'h0000, `DFA_CUR_FS_UA} : {16'h0000, `DFA_VOLT_FS_MV};
assign product = raw_ext * full_scale;
assign nxt_scaled = product >>> `DFA_DIGITS_SHIFT;

////////////////////////////////////////////////////////////////////////
// sample and scale every cycle
always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    reading_ff <= `DFA_READING_RESET;
    scaled_ff <= 32'h00000000;
  end
  else
  begin
    reading_ff <= raw_digits;
    scaled_ff <= nxt_scaled;
  end
end

endmodule
`default_nettype wire

// ==== core/dfa_regs.v ====
// drive flags, analog inputs and dip switch object bank
// Function
// - legacy flag 0 and switched on: pwm duty fixed at half, no holding torque.
// - legacy flag 1 and switched on: controller drives pwm, holding torque built.
// - field override 0: built-in default field orientation applies.
// - field override 1: rotating field forced non-inverted, positive sense.
// - field override -1: rotating field forced inverted, negative sense.
// - keep-gains 0: auto setup detects motor type and loads matching preset.
// - keep-gains 1: auto setup uses stored gains and leaves them unmodified.
// - each analog input read as signed 16-bit read-only digit count.
// - voltage mode: 1024 digits correspond to 10 volts.
// - current mode: 1024 digits correspond to 20 milliamperes.
// - select bit 0 means voltage, 1 means current measurement.
// - select bit 0 configures input 1, bit 1 configures input 2.
// - dip switches sampled once at restart, held until next restart.
// - field override write applies only after restart; auto setup then needed.
`default_nettype none
`include "dfa_defs.vh"

module dfa_regs
#(
  parameter PWM_W = 10
)
(
  input wire clk,
  input wire arst_n,
  input wire od_req,
  input wire od_wr,
  input wire [15:0] od_index,
  input wire [7:0] od_subindex,
  input wire [31:0] od_wdata,
  output reg od_ack_ff,
  output reg od_err_ff,
  output reg [31:0] od_rdata_ff,
  input wire ctrl_restart,
  input wire state_switched_on,
  input wire [PWM_W-1:0] ctrl_duty,
  output reg [PWM_W-1:0] pwm_duty_ff,
  output reg holding_torque_ff,
  input wire fw_default_invert,
  output reg field_invert_ff,
  output reg autosetup_required_ff,
  input wire autosetup_start,
  input wire motor_is_bldc,
  input wire autosetup_run_done,
  output reg autosetup_busy_ff,
  output reg autosetup_use_stored_ff,
  output reg preset_load_ff,
  output reg preset_bldc_ff,
  output reg gain_write_protect_ff,
  output reg autosetup_done_ff,
  input wire [15:0] ain1_raw,
  input wire [15:0] ain2_raw,
  output reg input_one_current_select,
  output reg input_two_current_select,
  output wire [31:0] ain1_scaled,
  output wire [31:0] ain2_scaled,
  input wire [15:0] dip_sw,
  output reg [15:0] dip_snapshot_ff
);

////////////////////////////////////////////////////////////////////////
// declarations
localparam [PWM_W-1:0] PWM_HALF = {1'b1, {(PWM_W-1){1'b0}}};

reg [7:0] legacy_power_ff;
reg [7:0] field_dir_ff;
reg [7:0] field_dir_applied_ff;
reg [7:0] keep_gains_ff;
reg [`DFA_SEL_W-1:0] meas_sel_ff;
reg restart_ff;
reg [1:0] as_state_ff;
reg [1:0] nxt_as_state;
reg nxt_preset_load;
reg nxt_preset_bldc;
reg nxt_use_stored;
reg nxt_as_done;
reg [31:0] nxt_rdata;
reg nxt_err;
wire restart_evt;
wire wr_evt;
wire [15:0] reading_one;
wire [15:0] reading_two;
wire [1:0] chan_sel;
wire [31:0] chan_scaled [0:1];
wire [15:0] chan_reading [0:1];
wire [15:0] chan_raw [0:1];
wire legacy_on;
wire keep_on;
wire field_invert_nxt;

////////////////////////////////////////////////////////////////////////
// decode helpers
function [31:0] sext8;
  input [7:0] v;
  begin
    sext8 = {{24{v[7]}}, v};
  end
endfunction

function [31:0] sext16;
  input [15:0] v;
  begin
    sext16 = {{16{v[15]}}, v};
  end
endfunction

function hit;
  input [15:0] idx;
  input [7:0] sub;
  input [15:0] want_idx;
  input [7:0] want_sub;
  begin
    hit = (idx == want_idx) && (sub == want_sub);
  end
endfunction

////////////////////////////////////////////////////////////////////////
// analog channels
assign chan_sel[0] = meas_sel_ff[`DFA_SEL_AIN1_BIT];
assign chan_sel[1] = meas_sel_ff[`DFA_SEL_AIN2_BIT];
assign chan_raw[0] = ain1_raw;
assign chan_raw[1] = ain2_raw;

genvar gi;
generate
  for (gi = 0; gi < 2; gi = gi + 1)
  begin : g_chan
    dfa_ain_chan u_chan
    (
      .clk(clk),
      .arst_n(arst_n),
      .raw_digits(chan_raw[gi]),
      .current_sel(chan_sel[gi]),
      .reading_ff(chan_reading[gi]),
      .scaled_ff(chan_scaled[gi])
    );
  end
endgenerate

assign reading_one = chan_reading[0];
assign reading_two = chan_reading[1];
assign ain1_scaled = chan_scaled[0];
assign ain2_scaled = chan_scaled[1];

////////////////////////////////////////////////////////////////////////
// restart: the cycle after reset release, or a controller restart
assign restart_evt = restart_ff | ctrl_restart;

always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    restart_ff <= 1'b1;
    dip_snapshot_ff <= `DFA_DIP_RESET;
    field_dir_applied_ff <= `DFA_DIR_DEFAULT;
  end
  else
  begin
    restart_ff <= 1'b0;
    if (restart_evt)
    begin
      dip_snapshot_ff <= dip_sw;
      field_dir_applied_ff <= field_dir_ff;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// object writes
assign wr_evt = od_req && od_wr;

always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    legacy_power_ff <= `DFA_FLAG_RESET;
    field_dir_ff <= `DFA_FLAG_RESET;
    keep_gains_ff <= `DFA_FLAG_RESET;
    meas_sel_ff <= `DFA_SEL_RESET;
  end
  else if (wr_evt)
  begin
    if (hit(od_index, od_subindex, `DFA_IDX_DRIVE_FLAGS, `DFA_SUB_ONE))
    begin
      legacy_power_ff <= od_wdata[7:0];
    end
    else if (hit(od_index, od_subindex, `DFA_IDX_DRIVE_FLAGS, `DFA_SUB_TWO))
    begin
      field_dir_ff <= od_wdata[7:0];
    end
    else if (hit(od_index, od_subindex, `DFA_IDX_DRIVE_FLAGS, `DFA_SUB_THREE))
    begin
      keep_gains_ff <= od_wdata[7:0];
    end
    else if (hit(od_index, od_subindex, `DFA_IDX_ANALOG_SEL, `DFA_SUB_COUNT))
    begin
      meas_sel_ff <= od_wdata[`DFA_SEL_W-1:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// object reads and abort decode
always @*
begin
  nxt_rdata = 32'h00000000;
  nxt_err = 1'b0;
  if (hit(od_index, od_subindex, `DFA_IDX_DRIVE_FLAGS, `DFA_SUB_COUNT))
  begin
    nxt_rdata = {24'h000000, `DFA_DRIVE_FLAGS_COUNT};
    nxt_err = od_wr;
  end
  else if (hit(od_index, od_subindex, `DFA_IDX_DRIVE_FLAGS, `DFA_SUB_ONE))
  begin
    nxt_rdata = sext8(legacy_power_ff);
  end
  else if (hit(od_index, od_subindex, `DFA_IDX_DRIVE_FLAGS, `DFA_SUB_TWO))
  begin
    nxt_rdata = sext8(field_dir_ff);
  end
  else if (hit(od_index, od_subindex, `DFA_IDX_DRIVE_FLAGS, `DFA_SUB_THREE))
  begin
    nxt_rdata = sext8(keep_gains_ff);
  end
  else if (hit(od_index, od_subindex, `DFA_IDX_ANALOG_IN, `DFA_SUB_COUNT))
  begin
    nxt_rdata = {24'h000000, `DFA_ANALOG_COUNT};
    nxt_err = od_wr;
  end
  else if (hit(od_index, od_subindex, `DFA_IDX_ANALOG_IN, `DFA_SUB_ONE))
  begin
    nxt_rdata = sext16(reading_one);
    nxt_err = od_wr;
  end
  else if (hit(od_index, od_subindex, `DFA_IDX_ANALOG_IN, `DFA_SUB_TWO))
  begin
    nxt_rdata = sext16(reading_two);
    nxt_err = od_wr;
  end
  else if (hit(od_index, od_subindex, `DFA_IDX_ANALOG_SEL, `DFA_SUB_COUNT))
  begin
    nxt_rdata = {{(32-`DFA_SEL_W){1'b0}}, meas_sel_ff};
  end
  else if (hit(od_index, od_subindex, `DFA_IDX_DIP_SW, `DFA_SUB_COUNT))
  begin
    nxt_rdata = {24'h000000, `DFA_DIP_COUNT};
    nxt_err = od_wr;
  end
  else if (hit(od_index, od_subindex, `DFA_IDX_DIP_SW, `DFA_SUB_ONE))
  begin
    nxt_rdata = {16'h0000, dip_snapshot_ff};
    nxt_err = od_wr;
  end
  else
  begin
    nxt_err = 1'b1;
  end
end

always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    od_ack_ff <= 1'b0;
    od_err_ff <= 1'b0;
    od_rdata_ff <= 32'h00000000;
  end
  else
  begin
    od_ack_ff <= od_req;
    od_err_ff <= od_req & nxt_err;
    od_rdata_ff <= (od_req && !od_wr && !nxt_err) ? nxt_rdata : 32'h00000000;
  end
end

////////////////////////////////////////////////////////////////////////
// drive outputs: pwm, field direction, select bits
assign legacy_on = (legacy_power_ff == `DFA_FLAG_ON);
assign keep_on = (keep_gains_ff == `DFA_FLAG_ON);
assign field_invert_nxt = (field_dir_applied_ff == `DFA_DIR_POSITIVE) ? 1'b0 :
                          (field_dir_applied_ff == `DFA_DIR_NEGATIVE) ? 1'b1 :
                          fw_default_invert;

always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    pwm_duty_ff <= PWM_HALF;
    holding_torque_ff <= 1'b0;
    field_invert_ff <= 1'b0;
    input_one_current_select <= 1'b0;
    input_two_current_select <= 1'b0;
  end
  else
  begin
    if (state_switched_on && !legacy_on)
    begin
      pwm_duty_ff <= PWM_HALF;
      holding_torque_ff <= 1'b0;
    end
    else
    begin
      pwm_duty_ff <= ctrl_duty;
      holding_torque_ff <= state_switched_on;
    end
    field_invert_ff <= field_invert_nxt;
    input_one_current_select <= meas_sel_ff[`DFA_SEL_AIN1_BIT];
    input_two_current_select <= meas_sel_ff[`DFA_SEL_AIN2_BIT];
  end
end

////////////////////////////////////////////////////////////////////////
// auto setup sequencer
always @*
begin
  nxt_as_state = as_state_ff;
  nxt_preset_load = 1'b0;
  nxt_preset_bldc = preset_bldc_ff;
  nxt_use_stored = autosetup_use_stored_ff;
  nxt_as_done = 1'b0;
  case (as_state_ff)
    `DFA_AS_IDLE:
    begin
      if (autosetup_start)
      begin
        if (keep_on)
        begin
          nxt_use_stored = 1'b1;
          nxt_as_state = `DFA_AS_RUN;
        end
        else
        begin
          nxt_use_stored = 1'b0;
          nxt_as_state = `DFA_AS_DETECT;
        end
      end
    end
    `DFA_AS_DETECT:
    begin
      nxt_preset_bldc = motor_is_bldc;
      nxt_as_state = `DFA_AS_LOAD;
    end
    `DFA_AS_LOAD:
    begin
      nxt_preset_load = 1'b1;
      nxt_as_state = `DFA_AS_RUN;
    end
    `DFA_AS_RUN:
    begin
      if (autosetup_run_done)
      begin
        nxt_as_done = 1'b1;
        nxt_as_state = `DFA_AS_IDLE;
      end
    end
    default:
    begin
      nxt_as_state = `DFA_AS_IDLE;
    end
  endcase
end

always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    as_state_ff <= `DFA_AS_IDLE;
    preset_load_ff <= 1'b0;
    preset_bldc_ff <= 1'b0;
    autosetup_use_stored_ff <= 1'b0;
    autosetup_done_ff <= 1'b0;
    autosetup_busy_ff <= 1'b0;
    gain_write_protect_ff <= 1'b0;
    autosetup_required_ff <= 1'b0;
  end
  else
  begin
    as_state_ff <= nxt_as_state;
    preset_load_ff <= nxt_preset_load;
    preset_bldc_ff <= nxt_preset_bldc;
    autosetup_use_stored_ff <= nxt_use_stored;
    autosetup_done_ff <= nxt_as_done;
    autosetup_busy_ff <= (nxt_as_state != `DFA_AS_IDLE);
    gain_write_protect_ff <= (nxt_as_state != `DFA_AS_IDLE) && nxt_use_stored;
    if (restart_evt && (field_dir_ff != field_dir_applied_ff))
    begin
      autosetup_required_ff <= 1'b1;
    end
    else if (nxt_as_done)
    begin
      autosetup_required_ff <= 1'b0;
    end
  end
end

endmodule
`default_nettype wire

// ==== tb/dfa_regs_sva.sv ====
// assertions for the drive flags and analog input bank
`default_nettype none
`include "dfa_defs.vh"
module dfa_regs_sva
#(
  parameter PWM_W = 10
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic od_req,
  input wire logic od_wr,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_subindex,
  input wire logic [31:0] od_wdata,
  input wire logic od_ack_ff,
  input wire logic od_err_ff,
  input wire logic [31:0] od_rdata_ff,
  input wire logic ctrl_restart,
  input wire logic state_switched_on,
  input wire logic [PWM_W-1:0] ctrl_duty,
  input wire logic [PWM_W-1:0] pwm_duty_ff,
  input wire logic holding_torque_ff,
  input wire logic fw_default_invert,
  input wire logic field_invert_ff,
  input wire logic autosetup_busy_ff,
  input wire logic autosetup_use_stored_ff,
  input wire logic preset_load_ff,
  input wire logic gain_write_protect_ff,
  input wire logic input_one_current_select,
  input wire logic input_two_current_select,
  input wire logic [15:0] dip_sw,
  input wire logic [15:0] dip_snapshot_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam [PWM_W-1:0] half_duty = 1 << (PWM_W - 1);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire sel_hit = od_req && od_index == `DFA_IDX_ANALOG_SEL && od_subindex == `DFA_SUB_COUNT;
  sequence s_preset_start;
    $rose(autosetup_busy_ff) && !autosetup_use_stored_ff;
  endsequence
  sequence s_stored_start;
    $rose(autosetup_busy_ff) && autosetup_use_stored_ff;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_ro_write_err: assert property (od_req && od_wr && (od_index == `DFA_IDX_ANALOG_IN ||
    od_index == `DFA_IDX_DIP_SW) |=> od_ack_ff && od_err_ff) else $error("read-only write not refused");
  a_sel_write_bits: assert property (sel_hit && od_wr |=> ##1
    {input_two_current_select, input_one_current_select} == $past(od_wdata[1:0], 2))
    else $error("select bits wrong");
  a_sel_read_zero: assert property (sel_hit && !od_wr |=> od_rdata_ff ==
    {30'h0, input_two_current_select, input_one_current_select}) else $error("select readback wrong");
  a_dip_capture: assert property (ctrl_restart |=> dip_snapshot_ff == $past(dip_sw))
    else $error("dip snapshot not captured");
  a_dip_hold: assert property (!ctrl_restart && $past(arst_n) |=> $stable(dip_snapshot_ff))
    else $error("dip snapshot moved");
  a_field_hold: assert property ($past(arst_n, 2) && !$past(ctrl_restart) && $stable(fw_default_invert)
    |=> $stable(field_invert_ff)) else $error("field changed without restart");
  a_half_duty: assert property ($past(state_switched_on) && !holding_torque_ff |-> pwm_duty_ff == half_duty)
    else $error("duty not half");
  a_ctrl_duty: assert property (holding_torque_ff |-> pwm_duty_ff == $past(ctrl_duty) &&
    $past(state_switched_on)) else $error("controller duty not passed");
  a_preset_seq: assert property (s_preset_start |-> ##2 preset_load_ff)
    else $error("preset not loaded");
  a_stored_run: assert property (s_stored_start |-> gain_write_protect_ff ##1 !preset_load_ff ##1
    !preset_load_ff) else $error("stored gains touched");
endmodule
bind dfa_regs dfa_regs_sva #(.PWM_W(PWM_W)) dfa_regs_sva_inst (.clk(clk), .arst_n(arst_n), .od_req(od_req),
  .od_wr(od_wr), .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata), .od_ack_ff(od_ack_ff),
  .od_err_ff(od_err_ff), .od_rdata_ff(od_rdata_ff), .ctrl_restart(ctrl_restart),
  .state_switched_on(state_switched_on), .ctrl_duty(ctrl_duty), .pwm_duty_ff(pwm_duty_ff),
  .holding_torque_ff(holding_torque_ff), .fw_default_invert(fw_default_invert),
  .field_invert_ff(field_invert_ff), .autosetup_busy_ff(autosetup_busy_ff),
  .autosetup_use_stored_ff(autosetup_use_stored_ff), .preset_load_ff(preset_load_ff),
  .gain_write_protect_ff(gain_write_protect_ff), .input_one_current_select(input_one_current_select),
  .input_two_current_select(input_two_current_select), .dip_sw(dip_sw), .dip_snapshot_ff(dip_snapshot_ff));
`default_nettype wire

// ==== tb/tb.sv ====
// testbench for the drive flags and analog input bank
`default_nettype none
`include "dfa_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, od_req, od_wr, ctrl_restart, state_switched_on, fw_default_invert;
  logic autosetup_start, motor_is_bldc, autosetup_run_done, er;
  logic [15:0] od_index, ain1_raw, ain2_raw, dip_sw, dip_snapshot_ff;
  logic [7:0] od_subindex;
  logic [31:0] od_wdata, od_rdata_ff, ain1_scaled, ain2_scaled, rd;
  logic [9:0] ctrl_duty, pwm_duty_ff;
  logic od_ack_ff, od_err_ff, holding_torque_ff, field_invert_ff, autosetup_required_ff, autosetup_busy_ff;
  logic autosetup_use_stored_ff, preset_load_ff, preset_bldc_ff, gain_write_protect_ff, autosetup_done_ff;
  logic input_one_current_select, input_two_current_select;
  int failures, compares, n;
  dfa_regs #(.PWM_W(10)) dfa_regs_inst (.clk(clk), .arst_n(arst_n), .od_req(od_req), .od_wr(od_wr),
    .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata), .od_ack_ff(od_ack_ff),
    .od_err_ff(od_err_ff), .od_rdata_ff(od_rdata_ff), .ctrl_restart(ctrl_restart),
    .state_switched_on(state_switched_on), .ctrl_duty(ctrl_duty), .pwm_duty_ff(pwm_duty_ff),
    .holding_torque_ff(holding_torque_ff), .fw_default_invert(fw_default_invert),
    .field_invert_ff(field_invert_ff), .autosetup_required_ff(autosetup_required_ff),
    .autosetup_start(autosetup_start), .motor_is_bldc(motor_is_bldc), .autosetup_run_done(autosetup_run_done),
    .autosetup_busy_ff(autosetup_busy_ff), .autosetup_use_stored_ff(autosetup_use_stored_ff),
    .preset_load_ff(preset_load_ff), .preset_bldc_ff(preset_bldc_ff),
    .gain_write_protect_ff(gain_write_protect_ff), .autosetup_done_ff(autosetup_done_ff), .ain1_raw(ain1_raw),
    .ain2_raw(ain2_raw), .input_one_current_select(input_one_current_select),
    .input_two_current_select(input_two_current_select), .ain1_scaled(ain1_scaled), .ain2_scaled(ain2_scaled),
    .dip_sw(dip_sw), .dip_snapshot_ff(dip_snapshot_ff));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    @(posedge clk);
    od_req <= 1'b1;
    od_wr <= w;
    od_index <= i;
    od_subindex <= s;
    od_wdata <= d;
    @(posedge clk);
    od_req <= 1'b0;
    #1;
    chk("ack", 32'(od_ack_ff), 32'h1);
    rd = od_rdata_ff;
    er = od_err_ff;
  endtask
  task rdc(input logic [15:0] i, input logic [7:0] s, input logic [31:0] exp);
    acc(1'b0, i, s, 32'h0);
    chk("read err", 32'(er), 32'h0);
    chk("rdata", rd, exp);
  endtask
  task wrc(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic e);
    acc(1'b1, i, s, d);
    chk("write err", 32'(er), 32'(e));
  endtask
  task restart;
    @(posedge clk);
    ctrl_restart <= 1'b1;
    @(posedge clk);
    ctrl_restart <= 1'b0;
    tick(2);
  endtask
  task autoset(input logic keep);
    @(posedge clk);
    autosetup_start <= 1'b1;
    @(posedge clk);
    autosetup_start <= 1'b0;
    #1;
    chk("busy", 32'(autosetup_busy_ff), 32'h1);
    chk("stored", 32'(autosetup_use_stored_ff), 32'(keep));
    chk("protect", 32'(gain_write_protect_ff), 32'(keep));
    if (!keep)
    begin
      tick(2);
      chk("preset load", 32'(preset_load_ff), 32'h1);
      chk("preset bldc", 32'(preset_bldc_ff), 32'(motor_is_bldc));
    end
    @(posedge clk);
    autosetup_run_done <= 1'b1;
    @(posedge clk);
    autosetup_run_done <= 1'b0;
    #1;
    chk("done", 32'(autosetup_done_ff), 32'h1);
    chk("required", 32'(autosetup_required_ff), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #100us;
    failures++;
    results();
  end
  initial
  begin
    {arst_n, od_req, od_wr, od_index, od_subindex, od_wdata, ctrl_restart, state_switched_on} = '0;
    {autosetup_start, autosetup_run_done} = '0;
    {fw_default_invert, motor_is_bldc, ctrl_duty} = {2'h3, 10'h123};
    {ain1_raw, ain2_raw, dip_sw} = {16'h0400, 16'hfe00, 16'ha5c3};
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    // reset values, read-only and unmapped objects
    rdc(`DFA_IDX_DRIVE_FLAGS, `DFA_SUB_COUNT, 32'h3);
    for (n = 1; n < 4; n++)
      rdc(`DFA_IDX_DRIVE_FLAGS, 8'(n), 32'h0);
    rdc(`DFA_IDX_ANALOG_IN, `DFA_SUB_COUNT, 32'h2);
    rdc(`DFA_IDX_ANALOG_SEL, `DFA_SUB_COUNT, 32'h0);
    rdc(`DFA_IDX_DIP_SW, `DFA_SUB_ONE, 32'ha5c3);
    wrc(`DFA_IDX_DRIVE_FLAGS, `DFA_SUB_COUNT, 32'h1, 1'b1);
    wrc(`DFA_IDX_ANALOG_IN, `DFA_SUB_ONE, 32'h5, 1'b1);
    wrc(`DFA_IDX_DIP_SW, `DFA_SUB_ONE, 32'h0, 1'b1);
    wrc(16'h3230, `DFA_SUB_COUNT, 32'h0, 1'b1);
    // measurement select and scaling
    wrc(`DFA_IDX_ANALOG_SEL, `DFA_SUB_COUNT, 32'hffffffff, 1'b0);
    rdc(`DFA_IDX_ANALOG_SEL, `DFA_SUB_COUNT, 32'h3);
    wrc(`DFA_IDX_ANALOG_SEL, `DFA_SUB_COUNT, 32'h1, 1'b0);
    tick(2);
    chk("sel one", 32'({input_two_current_select, input_one_current_select}), 32'h1);
    chk("ain1 current", ain1_scaled, 32'h4e20);
    chk("ain2 voltage", ain2_scaled, 32'hffffec78);
    rdc(`DFA_IDX_ANALOG_IN, `DFA_SUB_ONE, 32'h400);
    rdc(`DFA_IDX_ANALOG_IN, `DFA_SUB_TWO, 32'hfffffe00);
    wrc(`DFA_IDX_ANALOG_SEL, `DFA_SUB_COUNT, 32'h2, 1'b0);
    tick(2);
    chk("ain1 voltage", ain1_scaled, 32'h2710);
    chk("ain2 current", ain2_scaled, 32'hffffd8f0);
    // duty in the switched-on state
    @(posedge clk);
    state_switched_on <= 1'b1;
    tick(2);
    chk("half duty", 32'(pwm_duty_ff), 32'h200);
    chk("no torque", 32'(holding_torque_ff), 32'h0);
    wrc(`DFA_IDX_DRIVE_FLAGS, `DFA_SUB_ONE, 32'h1, 1'b0);
    tick(2);
    chk("ctrl duty", 32'(pwm_duty_ff), 32'h123);
    chk("torque", 32'(holding_torque_ff), 32'h1);
    // field override and dip snapshot across restarts
    chk("field default", 32'(field_invert_ff), 32'h1);
    @(posedge clk);
    dip_sw <= 16'h0f0f;
    wrc(`DFA_IDX_DRIVE_FLAGS, `DFA_SUB_TWO, 32'h1, 1'b0);
    tick(3);
    chk("field pending", 32'(field_invert_ff), 32'h1);
    chk("dip held", 32'(dip_snapshot_ff), 32'ha5c3);
    rdc(`DFA_IDX_DRIVE_FLAGS, `DFA_SUB_TWO, 32'h1);
    restart();
    chk("field positive", 32'(field_invert_ff), 32'h0);
    chk("setup required", 32'(autosetup_required_ff), 32'h1);
    chk("dip new", 32'(dip_snapshot_ff), 32'h0f0f);
    wrc(`DFA_IDX_DRIVE_FLAGS, `DFA_SUB_TWO, 32'hff, 1'b0);
    rdc(`DFA_IDX_DRIVE_FLAGS, `DFA_SUB_TWO, 32'hffffffff);
    restart();
    chk("field negative", 32'(field_invert_ff), 32'h1);
    // auto setup with bldc preset, stepper preset and stored gains
    autoset(1'b0);
    @(posedge clk);
    motor_is_bldc <= 1'b0;
    autoset(1'b0);
    wrc(`DFA_IDX_DRIVE_FLAGS, `DFA_SUB_THREE, 32'h1, 1'b0);
    autoset(1'b1);
    results();
  end
endmodule
`default_nettype wire
